// ===== rtl/ees_i2c_slave.sv
/*
  Two-wire slave of a paged EEPROM: start/stop detection, device address
  match, word address, page and identification page writes, reads, lock,
  write protect and the self-timed write cycle with acknowledge polling.
  Assumes the bus pins arrive asynchronously, a memory outside that takes
  page-latch loads and a commit pulse, and answers reads combinationally.
*/
// Behaviour
// - data moves only while clock low
// - falling data, clock high: start
// - rising data, clock high: stop, standby
// - ack each accepted byte on ninth clock
// - standby at power-up and after operations
// - address word 1010, selects, direction bit
// - compare select bits with strap inputs
// - direction one reads, zero writes
// - ack on match, else back to standby
// - protect pin high blocks array writes
// - 512 pages of 128, 16-bit address
// - byte write: two address bytes, data
// - stop starts 3 ms cycle, inputs ignored
// - page write up to 128 bytes
// - only low seven address bits increment (reads step the whole 16-bit address)
// - ID page writes use type 1011
// - locked ID page: no data acks (lock-select bytes are still acked)
// - polling acked only after cycle ends
// - sample on rise, drive after fall
// - data line driven low only
// - lock byte write sets permanent lock (srst_i clears it)
`timescale 1ns/100ps
module ees_i2c_slave
  import ees_pkg::*;
#(
  parameter int unsigned WR_CYC     = INTERNAL_WRITE_TIME_CYC,
  parameter int unsigned FIFO_DEPTH = LATCH_FIFO_DEPTH
)(
  input  logic              core_clk_i,
  input  logic              srst_i,
  input  logic              scl_i,
  input  logic              sda_i,
  output logic              sda_o,
  output logic              sda_oe_o,
  input  logic [2:0]        chip_select_straps_i,
  input  logic              write_protect_pin_i,
  output logic [ADDR_W-1:0] rd_addr_o,
  output logic              rd_id_o,
  input  logic [7:0]        rd_data_i,
  output logic              ld_valid_o,
  input  logic              ld_ready_i,
  output logic              ld_id_o,
  output logic [ADDR_W-1:0] ld_addr_o,
  output logic [7:0]        ld_data_o,
  output logic              commit_o,
  output logic              busy_o,
  output logic              standby_o,
  output logic              id_locked_o
);

  localparam int TMR_W = $clog2(WR_CYC + 1);

  if (WR_CYC < 1 || FIFO_DEPTH < 2)
  begin : g_chk
    $error("ees_i2c_slave: WR_CYC must be >= 1 and FIFO_DEPTH >= 2");
  end

  function automatic logic dev_match(input logic [7:0] w, input logic [2:0] cs);
    dev_match = (w[7:4] == DEV_TYPE_MAIN || w[7:4] == DEV_TYPE_ID)
                && w[3:1] == cs;
  endfunction : dev_match

  logic              scl_s;
  logic              sda_s;
  logic              wp_s;
  logic [2:0]        cs_s;
  logic              scl_d_q;
  logic              sda_d_q;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_w;
  logic              stop_w;
  logic              byte_end_w;
  ees_state_t        st_q;
  logic [3:0]        cnt_q;
  logic              ackph_q;
  logic [7:0]        sh_q;
  logic [7:0]        tx_q;
  logic              oe_q;
  logic              sda_q;
  logic [ADDR_W-1:0] addr_q;
  logic              id_sel_q;
  logic              mack_q;
  logic              pend_q;
  logic              lockrq_q;
  logic              push_q;
  logic [LATCH_W-1:0] fin_q;
  logic              fin_ready;
  logic              fout_valid;
  logic              fout_ready;
  logic [LATCH_W-1:0] fout_data;
  logic              ld_valid_q;
  logic [LATCH_W-1:0] ld_q;
  logic              busy_q;
  logic              drain_q;
  logic [TMR_W-1:0]  tmr_q;
  logic              commit_q;
  logic              lockarm_q;
  logic              locked_q;
  logic              standby_q;

  ees_sync #(
    .W   (6),
    .RST (SYNC_RST)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .async_i    ({chip_select_straps_i, write_protect_pin_i, sda_i, scl_i}),
    .sync_o     ({cs_s, wp_s, sda_s, scl_s})
  );

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end
    else
    begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  // A data edge while the clock stays high is a condition, never a bit
  assign start_w    = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop_w     = scl_s & scl_d_q & ~sda_d_q & sda_s;
  assign scl_rise   = scl_s & ~scl_d_q;
  assign scl_fall   = ~scl_s & scl_d_q;
  assign byte_end_w = scl_fall & ~ackph_q & (cnt_q == BYTE_BITS);

  // Protocol engine: bits are taken on clock rise, the line moves after fall
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      st_q     <= ST_IDLE;
      cnt_q    <= '0;
      ackph_q  <= 1'b0;
      sh_q     <= '0;
      tx_q     <= '0;
      oe_q     <= 1'b0;
      addr_q   <= '0;
      id_sel_q <= 1'b0;
      mack_q   <= 1'b0;
      pend_q   <= 1'b0;
      lockrq_q <= 1'b0;
      push_q   <= 1'b0;
      fin_q    <= '0;
    end
    else
    begin
      push_q <= 1'b0;
      if (start_w)
      begin
        // Any start resynchronises, which is what bus recovery relies on
        st_q     <= ST_DEVADDR;
        cnt_q    <= '0;
        ackph_q  <= 1'b0;
        oe_q     <= 1'b0;
        pend_q   <= 1'b0;
        lockrq_q <= 1'b0;
      end
      else if (stop_w)
      begin
        st_q     <= ST_IDLE;
        cnt_q    <= '0;
        ackph_q  <= 1'b0;
        oe_q     <= 1'b0;
        pend_q   <= 1'b0;
        lockrq_q <= 1'b0;
      end
      else if (scl_rise && st_q != ST_IDLE)
      begin
        if (ackph_q)
        begin
          mack_q <= sda_s;
        end
        else
        begin
          cnt_q <= cnt_q + 4'h1;
          sh_q  <= {sh_q[6:0], sda_s};
        end
      end
      else if (scl_fall && st_q != ST_IDLE)
      begin
        if (ackph_q)
        begin
          ackph_q <= 1'b0;
          cnt_q   <= '0;
          oe_q    <= 1'b0;
          if (st_q == ST_RDATA)
          begin
            if (mack_q)
            begin
              st_q <= ST_IDLE;
            end
            else
            begin
              tx_q   <= rd_data_i;
              oe_q   <= ~rd_data_i[7];
              addr_q <= addr_q + 16'h0001;
            end
          end
        end
        else if (cnt_q == BYTE_BITS)
        begin
          ackph_q <= 1'b1;
          oe_q    <= 1'b0;
          unique case (st_q)
            ST_DEVADDR:
            begin
              // While the write cycle runs the address is not acknowledged
              if (dev_match(sh_q, cs_s) && !busy_q)
              begin
                oe_q     <= 1'b1;
                id_sel_q <= sh_q[7:4] == DEV_TYPE_ID;
                mack_q   <= 1'b0;
                st_q     <= sh_q[0] ? ST_RDATA : ST_ADDRH;
              end
              else
              begin
                st_q <= ST_IDLE;
              end
            end
            ST_ADDRH:
            begin
              oe_q         <= 1'b1;
              addr_q[15:8] <= sh_q;
              st_q         <= ST_ADDRL;
            end
            ST_ADDRL:
            begin
              oe_q        <= 1'b1;
              addr_q[7:0] <= sh_q;
              st_q        <= ST_WDATA;
            end
            ST_WDATA:
            begin
              if (id_sel_q && addr_q[ID_LOCK_SELECT_BIT])
              begin
                oe_q     <= 1'b1;
                lockrq_q <= lockrq_q | sh_q[LOCK_DATA_BIT];
              end
              else if (id_sel_q && locked_q)
              begin
                st_q <= ST_IDLE;
              end
              else if (!fin_ready)
              begin
                // Latch path stalled: refuse the byte rather than lose it
                st_q <= ST_IDLE;
              end
              else
              begin
                oe_q <= 1'b1;
                addr_q[PAGE_BITS-1:0] <= addr_q[PAGE_BITS-1:0] + 7'h01;
                fin_q <= {id_sel_q, addr_q, sh_q};
                if (id_sel_q || !wp_s)
                begin
                  push_q <= 1'b1;
                  pend_q <= 1'b1;
                end
              end
            end
            ST_RDATA:
            begin
              oe_q <= 1'b0;
            end
            ST_IDLE:
            begin
              oe_q <= 1'b0;
            end
          endcase
        end
        else if (st_q == ST_RDATA)
        begin
          oe_q <= ~tx_q[3'(4'h7 - cnt_q)];
        end
      end
    end
  end

  ees_fifo #(
    .WIDTH (LATCH_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (push_q),
    .in_ready_o  (fin_ready),
    .in_data_i   (fin_q),
    .out_valid_o (fout_valid),
    .out_ready_i (fout_ready),
    .out_data_o  (fout_data)
  );

  assign fout_ready = ~ld_valid_q | ld_ready_i;

  // Output stage keeps the latch-load port registered
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ld_valid_q <= 1'b0;
      ld_q       <= '0;
    end
    else if (fout_valid && fout_ready)
    begin
      ld_valid_q <= 1'b1;
      ld_q       <= fout_data;
    end
    else if (ld_ready_i)
    begin
      ld_valid_q <= 1'b0;
    end
  end

  // Write cycle: wait for the latch path to drain, commit, then time out
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      busy_q    <= 1'b0;
      drain_q   <= 1'b0;
      tmr_q     <= '0;
      commit_q  <= 1'b0;
      lockarm_q <= 1'b0;
      locked_q  <= 1'b0;
    end
    else
    begin
      commit_q <= 1'b0;
      if (stop_w && (pend_q || lockrq_q) && !busy_q)
      begin
        busy_q    <= 1'b1;
        drain_q   <= 1'b1;
        lockarm_q <= lockrq_q;
      end
      else if (drain_q)
      begin
        if (!fout_valid && !ld_valid_q && !push_q)
        begin
          drain_q  <= 1'b0;
          commit_q <= 1'b1;
          tmr_q    <= '0;
        end
      end
      else if (busy_q)
      begin
        if (tmr_q == TMR_W'(WR_CYC - 1))
        begin
          busy_q <= 1'b0;
          if (lockarm_q)
          begin
            locked_q <= 1'b1;
          end
        end
        else
        begin
          tmr_q <= tmr_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      standby_q <= 1'b1;
      sda_q     <= 1'b0;
    end
    else
    begin
      standby_q <= (st_q == ST_IDLE) && !busy_q;
      sda_q     <= 1'b0;
    end
  end

  assign sda_o       = sda_q;
  assign sda_oe_o    = oe_q;
  assign rd_addr_o   = addr_q;
  assign rd_id_o     = id_sel_q;
  assign ld_valid_o  = ld_valid_q;
  assign ld_id_o     = ld_q[LATCH_ID_POS];
  assign ld_addr_o   = ld_q[LATCH_ID_POS-1:8];
  assign ld_data_o   = ld_q[7:0];
  assign commit_o    = commit_q;
  assign busy_o      = busy_q;
  assign standby_o   = standby_q;
  assign id_locked_o = locked_q;

  AST_OE_AFTER_FALL: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    $changed(oe_q) |-> $past(scl_fall || start_w || stop_w))
    else $error("data line drive changed without a clock fall");

  AST_START_ADDR: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    start_w |=> st_q == ST_DEVADDR && !oe_q)
    else $error("start did not open an address phase");

  AST_STOP_STANDBY: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    stop_w && !pend_q && !lockrq_q && !busy_q |=> st_q == ST_IDLE ##1 standby_q)
    else $error("stop without write did not reach standby");

  AST_ACK_MATCH: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    byte_end_w && st_q == ST_DEVADDR && dev_match(sh_q, cs_s) && !busy_q
    |=> oe_q && ackph_q)
    else $error("matching address not acknowledged");

  AST_NACK_MISMATCH: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    byte_end_w && st_q == ST_DEVADDR && !dev_match(sh_q, cs_s)
    |=> !oe_q && st_q == ST_IDLE)
    else $error("foreign address acknowledged");

  AST_POLL_BUSY: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    byte_end_w && st_q == ST_DEVADDR && busy_q |=> !oe_q)
    else $error("address acknowledged during write cycle");

  AST_DIR_READ: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    byte_end_w && st_q == ST_DEVADDR && dev_match(sh_q, cs_s) && !busy_q
    |=> st_q == (sh_q[0] ? ST_RDATA : ST_ADDRH))
    else $error("direction bit not followed");

  AST_WP_NO_PUSH: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    push_q |-> $past(id_sel_q || !wp_s))
    else $error("protected array byte reached the latch");

  AST_PAGE_WRAP: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    push_q |-> addr_q[15:7] == $past(addr_q[15:7])
            && addr_q[6:0] == 7'($past(addr_q[6:0]) + 7'h01))
    else $error("page address did not wrap in page");

  AST_LOCK_NACK: assert property (
    @(posedge core_clk_i) disable iff (srst_i)
    byte_end_w && st_q == ST_WDATA && id_sel_q && locked_q
    && !addr_q[ID_LOCK_SELECT_BIT] |=> !oe_q)
    else $error("locked ID page byte acknowledged");

endmodule : ees_i2c_slave

// ===== rtl/ees_pkg.sv
/*
  Shared constants of the two-wire EEPROM slave read and write paths: device type
  codes, address layout, write-cycle timing and the protocol states.
  Assumes a 25 MHz core clock; all users import the whole package.
*/
package ees_pkg;

  localparam logic [3:0]  DEV_TYPE_MAIN         = 4'hA;
  localparam logic [3:0]  DEV_TYPE_ID           = 4'hB;
  localparam logic [3:0]  BYTE_BITS             = 4'h8;
  localparam int          ADDR_W                = 16;
  localparam int          PAGE_BITS             = 7;
  localparam int          ID_LOCK_SELECT_BIT    = 10;
  localparam int          LOCK_DATA_BIT         = 1;
  localparam int          LATCH_W               = 1 + ADDR_W + 8;
  localparam int          LATCH_ID_POS          = LATCH_W - 1;
  localparam int unsigned LATCH_FIFO_DEPTH      = 32;
  localparam int unsigned CLK_PERIOD_NS         = 40;
  localparam int unsigned INTERNAL_WRITE_TIME_NS = 3000000;
  localparam int unsigned INTERNAL_WRITE_TIME_CYC =
    INTERNAL_WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [5:0]  SYNC_RST              = 6'h03;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_DEVADDR = 6'h02,
    ST_ADDRH   = 6'h04,
    ST_ADDRL   = 6'h08,
    ST_WDATA   = 6'h10,
    ST_RDATA   = 6'h20
  } ees_state_t;

endpackage : ees_pkg

// ===== rtl/ees_sync.sv
/*
  Two-stage synchroniser for a group of level inputs from outside the
  core clock domain. Assumes each bit changes slowly against the clock.
*/
`timescale 1ns/100ps
module ees_sync #(
  parameter int unsigned    W   = 1,
  parameter logic [W-1:0]   RST = '0
)(
  input  logic             core_clk_i,
  input  logic             srst_i,
  input  logic [W-1:0]     async_i,
  output logic [W-1:0]     sync_o
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second one
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      meta_q <= RST;
      sync_o <= RST;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : ees_sync

// ===== rtl/ees_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides and honest full/empty.
  Assumes DEPTH is a power of two so the pointers wrap by themselves.
*/
`timescale 1ns/100ps
module ees_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
)(
  input  logic             core_clk_i,
  input  logic             srst_i,
  input  logic             in_valid_i,
  output logic             in_ready_o,
  input  logic [WIDTH-1:0] in_data_i,
  output logic             out_valid_o,
  input  logic             out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_chk
    $error("ees_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge core_clk_i)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= push ? wr_q + 1'b1 : wr_q;
      rd_q  <= pop ? rd_q + 1'b1 : rd_q;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule : ees_fifo

// ===== verification/ees_bus_model.sv
/*
  Behavioural two-wire bus controller: start, stop, byte out, byte in.
  Assumes a pull-up outside resolves sda_i from every pull-down enable.
*/
`timescale 1ns/100ps
module ees_bus_model (
  input  wire logic core_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  initial
  begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  // A quarter of the 320 ns bus period; the clock stands high between frames
  task automatic qtr();
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask : qtr

  task automatic start();
    sda_pull_o = 1'b0;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_pull_o = 1'b1;
    qtr();
    scl_o = 1'b0;
    qtr();
  endtask : start

  task automatic stop();
    sda_pull_o = 1'b1;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_pull_o = 1'b0;
    qtr();
  endtask : stop

  task automatic bit_io(input logic b, output logic s);
    sda_pull_o = ~b;
    qtr();
    scl_o = 1'b1;
    qtr();
    s = sda_i;
    qtr();
    scl_o = 1'b0;
    qtr();
  endtask : bit_io

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(~ack, s);
  endtask : rd_byte

  task automatic recover();
    logic s;
    repeat (9) bit_io(1'b1, s);
    start();
    stop();
  endtask : recover
endmodule : ees_bus_model

// ===== verification/ees_i2c_slave_tb.sv
/*
  Self-checking bench of the EEPROM slave: drives the bus through the
  controller model, records page-latch loads and write-cycle commits.
  Assumes a short write cycle parameter and a 32-entry load FIFO.
*/
`timescale 1ns/100ps
module ees_i2c_slave_tb
  import ees_pkg::*;
;
  localparam int unsigned WR = 200;
  logic        core_clk;
  logic        srst;
  logic        scl;
  logic        m_pull;
  logic        sda_w;
  logic        sda_o;
  logic        sda_oe;
  logic [2:0]  straps;
  logic        wp;
  logic [15:0] rd_addr;
  logic        rd_id;
  logic [7:0]  rd_data;
  logic        ld_valid;
  logic        ld_ready;
  logic        ld_id;
  logic [15:0] ld_addr;
  logic [7:0]  ld_data;
  logic        commit;
  logic        busy;
  logic        standby;
  logic        id_locked;
  logic [24:0] ldq[$];
  int          commits;
  int          cyc;
  int          err_total;
  int          num_checks;

  // Pull-up: the line is high unless some party pulls it low
  assign sda_w   = ~(m_pull | sda_oe);
  assign rd_data = rd_addr[7:0] ^ rd_addr[15:8] ^ {7'h00, rd_id};

  ees_bus_model m (
    .core_clk_i (core_clk),
    .sda_i      (sda_w),
    .scl_o      (scl),
    .sda_pull_o (m_pull)
  );

  ees_i2c_slave #(.WR_CYC(WR), .FIFO_DEPTH(32)) u_dut (
    .core_clk_i           (core_clk),
    .srst_i               (srst),
    .scl_i                (scl),
    .sda_i                (sda_w),
    .sda_o                (sda_o),
    .sda_oe_o             (sda_oe),
    .chip_select_straps_i (straps),
    .write_protect_pin_i  (wp),
    .rd_addr_o            (rd_addr),
    .rd_id_o              (rd_id),
    .rd_data_i            (rd_data),
    .ld_valid_o           (ld_valid),
    .ld_ready_i           (ld_ready),
    .ld_id_o              (ld_id),
    .ld_addr_o            (ld_addr),
    .ld_data_o            (ld_data),
    .commit_o             (commit),
    .busy_o               (busy),
    .standby_o            (standby),
    .id_locked_o          (id_locked)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (ld_valid === 1'b1 && ld_ready)
      ldq.push_back({ld_id, ld_addr, ld_data});
    if (commit === 1'b1)
      commits++;
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      err_total++;
    end
  endtask : check

  task automatic conclude();
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic wait_idle();
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 2000 && standby !== 1'b1; i++)
      @(posedge core_clk);
    #1;
  endtask : wait_idle

  task automatic hdr(input logic [3:0] t, input logic [15:0] a);
    logic k0, k1, k2;
    m.start();
    m.wr_byte({t, straps, 1'b0}, k0);
    m.wr_byte(a[15:8], k1);
    m.wr_byte(a[7:0], k2);
    check({k0, k1, k2}, 3'b111);
  endtask : hdr

  task automatic one_write(input logic [3:0] t, input logic [15:0] a,
                           input logic [7:0] d, input logic exp_ack);
    logic k;
    hdr(t, a);
    m.wr_byte(d, k);
    check(k, exp_ack);
    m.stop();
  endtask : one_write

  initial
  begin
    logic       k;
    logic [7:0] d;
    int         n;
    srst = 1'b1;
    straps = 3'h5;
    wp = 1'b0;
    ld_ready = 1'b1;
    repeat (16) @(posedge core_clk);
    #1;
    srst = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    check(standby, 1'b1);
    m.start();
    m.wr_byte({DEV_TYPE_MAIN, straps ^ 3'h1, 1'b0}, k);
    check(k, 1'b0);
    m.stop();
    m.start();
    m.wr_byte({4'h9, straps, 1'b0}, k);
    check(k, 1'b0);
    m.stop();
    one_write(DEV_TYPE_MAIN, 16'h1234, 8'hC3, 1'b1);
    m.start();
    m.wr_byte({DEV_TYPE_MAIN, straps, 1'b0}, k);
    check(k, 1'b0);
    check(busy, 1'b1);
    n = 0;
    while (k !== 1'b1 && n < 20)
    begin
      m.start();
      m.wr_byte({DEV_TYPE_MAIN, straps, 1'b0}, k);
      n++;
    end
    check(k, 1'b1);
    m.stop();
    wait_idle();
    check(commits, 1);
    check(ldq.pop_front(), {1'b0, 16'h1234, 8'hC3});
    // Crossing the page end shows whether the upper bits stay put
    hdr(DEV_TYPE_MAIN, 16'h127E);
    for (int i = 0; i < 130; i++)
    begin
      m.wr_byte(i[7:0], k);
      check(k, 1'b1);
    end
    m.stop();
    wait_idle();
    check(ldq.size(), 130);
    for (int i = 0; i < 130; i++)
      check(ldq.pop_front(), {1'b0, 9'h024, 7'(7'h7E + i), i[7:0]});
    wp = 1'b1;
    one_write(DEV_TYPE_MAIN, 16'h0100, 8'h5A, 1'b1);
    wait_idle();
    check(ldq.size(), 0);
    check(commits, 2);
    wp = 1'b0;
    one_write(DEV_TYPE_ID, 16'h0005, 8'h77, 1'b1);
    wait_idle();
    check(ldq.pop_front(), {1'b1, 16'h0005, 8'h77});
    one_write(DEV_TYPE_ID, 16'h0400, 8'h02, 1'b1);
    wait_idle();
    check(ldq.size(), 0);
    check(id_locked, 1'b1);
    one_write(DEV_TYPE_ID, 16'h0006, 8'h11, 1'b0);
    wait_idle();
    // Latch stalled: the FIFO must fill and then refuse further bytes
    ld_ready = 1'b0;
    hdr(DEV_TYPE_MAIN, 16'h2000);
    n = 0;
    k = 1'b1;
    while (k === 1'b1 && n < 40)
    begin
      m.wr_byte(8'hE0 ^ n[7:0], k);
      if (k === 1'b1)
        n++;
    end
    check(n >= 32 && n < 40, 1'b1);
    m.stop();
    ld_ready = 1'b1;
    wait_idle();
    check(ldq.size(), n);
    for (int i = 0; i < n; i++)
      check(ldq.pop_front(), {1'b0, 9'h040, i[6:0], 8'hE0 ^ i[7:0]});
    hdr(DEV_TYPE_MAIN, 16'h0040);
    m.start();
    m.wr_byte({DEV_TYPE_MAIN, straps, 1'b1}, k);
    check(k, 1'b1);
    m.rd_byte(1'b1, d);
    check(d, 8'h40);
    m.rd_byte(1'b0, d);
    check(d, 8'h41);
    m.stop();
    hdr(DEV_TYPE_ID, 16'h0010);
    m.start();
    m.wr_byte({DEV_TYPE_ID, straps, 1'b1}, k);
    m.rd_byte(1'b0, d);
    check({k, d}, 9'h111);
    m.stop();
    m.start();
    m.wr_byte(8'hFF, k);
    check(k, 1'b0);
    // Cut a read while the slave holds the line low, then recover
    m.start();
    m.wr_byte({DEV_TYPE_MAIN, straps, 1'b1}, k);
    check(k, 1'b1);
    m.recover();
    wait_idle();
    check({standby, busy, sda_oe, sda_o}, 4'b1000);
    conclude();
  end
endmodule : ees_i2c_slave_tb
